// *** hw/gtl_pkg.sv ***
// Package: constants and types for the grand total and limit warning block
package gtl_pkg;
    localparam int TOTAL_W = 32;

    // Count direction setting
    typedef enum logic [1:0] {
        GTL_DIR_UP   = 2'h0,
        GTL_DIR_DOWN = 2'h1,
        GTL_DIR_EXT  = 2'h2
    } gtl_dir_type;

    // Grand total policy
    typedef enum logic [2:0] {
        GTL_GT_NONE    = 3'h0,
        GTL_GT_FOLLOW  = 3'h1,
        GTL_GT_REVERSE = 3'h2,
        GTL_GT_UP_ONLY = 3'h3,
        GTL_GT_DN_ONLY = 3'h4,
        GTL_GT_ANY     = 3'h5,
        GTL_GT_RSVD    = 3'h6
    } gtl_gt_mode_type;

    // Warning style
    typedef enum logic [2:0] {
        GTL_WS_NONE  = 3'h0,
        GTL_WS_FLASH = 3'h1,
        GTL_WS_DASH  = 3'h2,
        GTL_WS_OVUN  = 3'h3,
        GTL_WS_HILO  = 3'h4
    } gtl_wstyle_type;

    // Presentation shown on the display
    typedef enum logic [2:0] {
        GTL_SHOW_VALUE = 3'h0,
        GTL_SHOW_BLANK = 3'h1,
        GTL_SHOW_DASH  = 3'h2,
        GTL_SHOW_HIGH  = 3'h3,
        GTL_SHOW_LOW   = 3'h4
    } gtl_show_type;

    // Selected view
    typedef enum logic [1:0] {
        GTL_VIEW_TOTAL = 2'h0,
        GTL_VIEW_GRAND = 2'h1,
        GTL_VIEW_RATE  = 2'h2
    } gtl_view_type;

    // Power-on / reset load option for the total
    typedef enum logic [1:0] {
        GTL_RST_OFF    = 2'h0,
        GTL_RST_ZERO   = 2'h1,
        GTL_RST_PRESET = 2'h2
    } gtl_rst_type;

    localparam logic [TOTAL_W-1:0] GTL_ZERO = 32'h0000_0000;
    localparam logic [TOTAL_W-1:0] GTL_ONE  = 32'h0000_0001;

    // Timing
    localparam longint GTL_CLK_HZ      = 200_000_000;
    localparam longint GTL_FLASH_MS    = 1000;
    localparam longint GTL_FLASH_CYC   = GTL_CLK_HZ * GTL_FLASH_MS / 1000;
    localparam longint GTL_LABEL_MS    = 1000;
    localparam longint GTL_LABEL_CYC   = GTL_CLK_HZ * GTL_LABEL_MS / 1000;
    localparam int     GTL_TIMER_W     = 28;
endpackage : gtl_pkg

// *** hw/gtl_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module gtl_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule // gtl_sync
`default_nettype wire

// *** hw/gtl_top.sv ***
// Grand total accumulator with limit warning and power-on clearing
`timescale 1ns/1ps
`default_nettype none
module gtl_top
    import gtl_pkg::*;
#(
    parameter int     TW        = gtl_pkg::TOTAL_W,
    parameter longint FLASH_CYC = gtl_pkg::GTL_FLASH_CYC,
    parameter longint LABEL_CYC = gtl_pkg::GTL_LABEL_CYC
) (
    input  wire logic                     I_CLOCK,
    input  wire logic                     I_RESET,
    input  wire logic                     I_PULSE,
    input  wire logic                     I_DIR_LEVEL,
    input  wire logic                     I_REMOTE_RESET,
    input  wire logic                     I_REMOTE_GRAND_CLEAR,
    input  wire logic                     I_BUTTON_GRAND_CLEAR,
    input  wire logic                     I_BUTTON_VIEW,
    input  wire gtl_pkg::gtl_dir_type     I_DIRECTION_MODE,
    input  wire gtl_pkg::gtl_gt_mode_type I_GRAND_MODE,
    input  wire logic                     I_COMBINED_MODE,
    input  wire logic                     I_GRAND_CLEAR_BY_REMOTE,
    input  wire logic                     I_GRAND_CLEAR_BY_BUTTON,
    input  wire logic                     I_LOW_LIMIT_ON,
    input  wire logic signed [TW-1:0]     I_LOW_WARNING_LIMIT,
    input  wire logic                     I_HIGH_LIMIT_ON,
    input  wire logic signed [TW-1:0]     I_HIGH_WARNING_LIMIT,
    input  wire gtl_pkg::gtl_wstyle_type  I_WARNING_STYLE,
    input  wire gtl_pkg::gtl_rst_type     I_POWER_ON_TOTAL_CLEAR,
    input  wire logic                     I_POWER_ON_GRAND_CLEAR,
    input  wire gtl_pkg::gtl_rst_type     I_RESET_OPTION,
    input  wire logic signed [TW-1:0]     I_PRESET_VALUE,
    output var  logic signed [TW-1:0]     O_TOTAL,
    output var  logic signed [TW-1:0]     O_GRAND_TOTAL,
    output var  logic                     O_LOW_WARNING,
    output var  logic                     O_HIGH_WARNING,
    output var  gtl_pkg::gtl_show_type    O_SHOW,
    output var  gtl_pkg::gtl_view_type    O_VIEW,
    output var  logic                     O_LABEL
);
    import gtl_pkg::*;

    //--------------------------------------------------------------------
    // Pin synchronisers and edge detection
    //--------------------------------------------------------------------
    localparam int NPIN = 6;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s;
    logic [NPIN-1:0] pin_prev_q;
    logic [NPIN-1:0] pin_prev_d;
    logic [NPIN-1:0] pin_rise;

    assign pin_raw = {I_BUTTON_VIEW, I_BUTTON_GRAND_CLEAR, I_REMOTE_GRAND_CLEAR,
                      I_REMOTE_RESET, I_DIR_LEVEL, I_PULSE};

    gtl_sync #(.WIDTH(NPIN)) u_sync (
        .i_clk   (I_CLOCK),
        .i_rst   (I_RESET),
        .i_async (pin_raw),
        .o_sync  (pin_s)
    );

    always_comb begin
        pin_prev_d = pin_s;
        pin_rise   = pin_s & ~pin_prev_q;
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            pin_prev_q <= '0;
        end else begin
            pin_prev_q <= pin_prev_d;
        end
    end

    logic pulse_ev;
    logic dir_lvl;
    logic rrst_ev;
    logic rgclr_ev;
    logic bgclr_ev;
    logic view_ev;
    assign pulse_ev = pin_rise[0];
    assign dir_lvl  = pin_s[1];
    assign rrst_ev  = pin_rise[2];
    assign rgclr_ev = pin_rise[3];
    assign bgclr_ev = pin_rise[4];
    assign view_ev  = pin_rise[5];

    //--------------------------------------------------------------------
    // Total and grand total
    //--------------------------------------------------------------------
    // Power-up init runs in the first cycle after reset release
    logic                 init_q;
    logic                 init_d;
    logic signed [TW-1:0] total_q;
    logic signed [TW-1:0] total_d;
    logic signed [TW-1:0] grand_q;
    logic signed [TW-1:0] grand_d;
    logic                 is_up;
    logic                 grand_clr;

    always_comb begin
        init_d  = 1'b0;
        total_d = total_q;
        grand_d = grand_q;
        unique case (I_DIRECTION_MODE)
            GTL_DIR_UP:   is_up = 1'b1;
            GTL_DIR_DOWN: is_up = 1'b0;
            GTL_DIR_EXT:  is_up = dir_lvl;
            default:      is_up = 1'b1;
        endcase
        grand_clr = (rgclr_ev && I_GRAND_CLEAR_BY_REMOTE)
                 || (bgclr_ev && I_GRAND_CLEAR_BY_BUTTON);
        if (pulse_ev) begin
            total_d = is_up ? total_q + GTL_ONE : total_q - GTL_ONE;
            unique case (I_GRAND_MODE)
                GTL_GT_FOLLOW:  grand_d = is_up ? grand_q + GTL_ONE : grand_q - GTL_ONE;
                GTL_GT_REVERSE: grand_d = is_up ? grand_q - GTL_ONE : grand_q + GTL_ONE;
                GTL_GT_UP_ONLY: grand_d = is_up ? grand_q + GTL_ONE : grand_q;
                GTL_GT_DN_ONLY: grand_d = is_up ? grand_q : grand_q + GTL_ONE;
                GTL_GT_ANY:     grand_d = grand_q + GTL_ONE;
                default:        grand_d = grand_q;
            endcase
        end
        // Clamp for non-negative policies, in case a signed value was left over
        if ((I_GRAND_MODE == GTL_GT_UP_ONLY || I_GRAND_MODE == GTL_GT_DN_ONLY
             || I_GRAND_MODE == GTL_GT_ANY) && grand_d < 0) begin
            grand_d = GTL_ZERO;
        end
        if (grand_clr) begin
            grand_d = GTL_ZERO;
        end
        if (rrst_ev) begin
            total_d = (I_RESET_OPTION == GTL_RST_PRESET) ? I_PRESET_VALUE : GTL_ZERO;
        end
        if (init_q) begin
            unique case (I_POWER_ON_TOTAL_CLEAR)
                GTL_RST_ZERO:   total_d = GTL_ZERO;
                GTL_RST_PRESET: total_d = I_PRESET_VALUE;
                default:        total_d = total_q;
            endcase
            grand_d = I_POWER_ON_GRAND_CLEAR ? GTL_ZERO : grand_q;
        end
    end

    // Totals model retained memory: reset does not touch them
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            init_q <= 1'b1;
        end else begin
            init_q <= init_d;
        end
        total_q <= total_d;
        grand_q <= grand_d;
    end

    //--------------------------------------------------------------------
    // Limit comparison and one-second flash
    //--------------------------------------------------------------------
    logic                   low_d;
    logic                   high_d;
    logic                   low_q;
    logic                   high_q;
    logic [GTL_TIMER_W-1:0] flash_cnt_q;
    logic [GTL_TIMER_W-1:0] flash_cnt_d;
    logic                   phase_q;
    logic                   phase_d;
    gtl_show_type           show_q;
    gtl_show_type           show_d;

    always_comb begin
        low_d       = I_LOW_LIMIT_ON && (total_q < I_LOW_WARNING_LIMIT);
        high_d      = I_HIGH_LIMIT_ON && (total_q > I_HIGH_WARNING_LIMIT);
        flash_cnt_d = flash_cnt_q + 1'b1;
        phase_d     = phase_q;
        if (flash_cnt_q == GTL_TIMER_W'(FLASH_CYC - 1)) begin
            flash_cnt_d = '0;
            phase_d     = ~phase_q;
        end
        show_d = GTL_SHOW_VALUE;
        if (low_q || high_q) begin
            unique case (I_WARNING_STYLE)
                GTL_WS_FLASH: show_d = phase_q ? GTL_SHOW_BLANK : GTL_SHOW_VALUE;
                GTL_WS_DASH:  show_d = phase_q ? GTL_SHOW_BLANK : GTL_SHOW_DASH;
                GTL_WS_OVUN,
                GTL_WS_HILO:  show_d = phase_q ? GTL_SHOW_BLANK
                                     : (high_q ? GTL_SHOW_HIGH : GTL_SHOW_LOW);
                default:      show_d = GTL_SHOW_VALUE;
            endcase
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            low_q       <= 1'b0;
            high_q      <= 1'b0;
            flash_cnt_q <= '0;
            phase_q     <= 1'b0;
            show_q      <= GTL_SHOW_VALUE;
        end else begin
            low_q       <= low_d;
            high_q      <= high_d;
            flash_cnt_q <= flash_cnt_d;
            phase_q     <= phase_d;
            show_q      <= show_d;
        end
    end

    //--------------------------------------------------------------------
    // View stepping with label
    //--------------------------------------------------------------------
    gtl_view_type           view_q;
    gtl_view_type           view_d;
    logic                   label_q;
    logic                   label_d;
    logic [GTL_TIMER_W-1:0] label_cnt_q;
    logic [GTL_TIMER_W-1:0] label_cnt_d;

    always_comb begin
        view_d      = view_q;
        label_d     = label_q;
        label_cnt_d = label_cnt_q;
        if (label_q) begin
            if (label_cnt_q == GTL_TIMER_W'(LABEL_CYC - 1)) begin
                label_d = 1'b0;
            end else begin
                label_cnt_d = label_cnt_q + 1'b1;
            end
        end
        if (view_ev) begin
            unique case (view_q)
                GTL_VIEW_TOTAL: view_d = GTL_VIEW_GRAND;
                GTL_VIEW_GRAND: view_d = I_COMBINED_MODE ? GTL_VIEW_RATE : GTL_VIEW_TOTAL;
                default:        view_d = GTL_VIEW_TOTAL;
            endcase
            label_d     = 1'b1;
            label_cnt_d = '0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            view_q      <= GTL_VIEW_TOTAL;
            label_q     <= 1'b0;
            label_cnt_q <= '0;
        end else begin
            view_q      <= view_d;
            label_q     <= label_d;
            label_cnt_q <= label_cnt_d;
        end
    end

    //--------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------
    logic signed [TW-1:0] out_total_q;
    logic signed [TW-1:0] out_grand_q;
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            out_total_q <= GTL_ZERO;
            out_grand_q <= GTL_ZERO;
        end else begin
            out_total_q <= total_q;
            out_grand_q <= grand_q;
        end
    end
    assign O_TOTAL        = out_total_q;
    assign O_GRAND_TOTAL  = out_grand_q;
    assign O_LOW_WARNING  = low_q;
    assign O_HIGH_WARNING = high_q;
    assign O_SHOW         = show_q;
    assign O_VIEW         = view_q;
    assign O_LABEL        = label_q;

    //--------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RESET || init_q);

    follow_up_a: assert property (pulse_ev && I_GRAND_MODE == GTL_GT_FOLLOW && is_up
        && !grand_clr |=> grand_q == $past(grand_q) + 1) else $error("follow up");
    reverse_up_a: assert property (pulse_ev && I_GRAND_MODE == GTL_GT_REVERSE && is_up
        && !grand_clr |=> grand_q == $past(grand_q) - 1) else $error("reverse up");
    none_hold_a: assert property (I_GRAND_MODE == GTL_GT_NONE && !grand_clr
        |=> grand_q == $past(grand_q)) else $error("none changed");
    rsvd_hold_a: assert property (I_GRAND_MODE == GTL_GT_RSVD && !grand_clr
        |=> grand_q == $past(grand_q)) else $error("reserved changed");
    any_add_a: assert property (pulse_ev && I_GRAND_MODE == GTL_GT_ANY && !grand_clr
        && grand_q >= 0 |=> grand_q == $past(grand_q) + 1) else $error("any pulse");
    grand_clr_a: assert property (grand_clr |=> grand_q == 0) else $error("grand clear");
    low_flag_a: assert property (I_LOW_LIMIT_ON && total_q < I_LOW_WARNING_LIMIT
        |=> O_LOW_WARNING) else $error("low flag");
    high_off_a: assert property (!I_HIGH_LIMIT_ON |=> !O_HIGH_WARNING)
        else $error("high disabled");
    style_none_a: assert property (I_WARNING_STYLE == GTL_WS_NONE
        |=> O_SHOW == GTL_SHOW_VALUE) else $error("none style");
    preset_load_a: assert property (rrst_ev && I_RESET_OPTION == GTL_RST_PRESET
        |=> total_q == $past(I_PRESET_VALUE)) else $error("preset");

    cov_warn_c:  cover property (O_HIGH_WARNING && O_SHOW == GTL_SHOW_HIGH);
    cov_clear_c: cover property (grand_clr);
    cov_view_c:  cover property (view_ev ##1 O_LABEL);
endmodule // gtl_top
`default_nettype wire

// *** bench/gtl_panel_model.sv ***
// Pulse input stage and front panel controls that drive the totaliser pins
`timescale 1ns/1ps
`default_nettype none
module gtl_panel_model (
    input  wire logic i_clk,
    output var  logic o_pulse,
    output var  logic o_dir_level,
    output wire logic o_remote_reset,
    output wire logic o_remote_grand_clear,
    output wire logic o_button_grand_clear,
    output wire logic o_button_view
);
    logic [3:0] key_q;

    assign o_remote_reset       = key_q[0];
    assign o_remote_grand_clear = key_q[1];
    assign o_button_grand_clear = key_q[2];
    assign o_button_view        = key_q[3];

    initial begin
        o_pulse     = 1'b0;
        o_dir_level = 1'b1;
        key_q       = 4'h0;
    end

    // Direction level settles a cycle ahead and stays put after the pulse
    task automatic send_pulse(input logic up);
        @(posedge i_clk);
        o_dir_level <= up;
        @(posedge i_clk);
        o_pulse <= 1'b1;
        repeat (3) @(posedge i_clk);
        o_pulse <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask

    // Held three clocks so the two-flop synchroniser cannot miss it
    task automatic press(input int which);
        @(posedge i_clk);
        key_q[which] <= 1'b1;
        repeat (3) @(posedge i_clk);
        key_q[which] <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
endmodule // gtl_panel_model
`default_nettype wire

// *** bench/test_grand_total_limit_warning.sv ***
// Self-checking testbench for the grand total and limit warning block
`timescale 1ns/1ps
`default_nettype none
module test_grand_total_limit_warning;
    import gtl_pkg::*;
    localparam int FL = 8;
    logic clk, rst, comb, gc_rem, gc_btn, lo_on, hi_on, po_grand;
    logic signed [31:0] lo_lim, hi_lim, preset, tot, grand, exp_t, exp_g;
    gtl_dir_type dir_mode;
    gtl_gt_mode_type gmode;
    gtl_wstyle_type style;
    gtl_rst_type po_tot, rst_opt;
    wire logic pulse, dir, rem_rst, rem_gc, btn_gc, btn_view;
    logic lw, hw, label;
    gtl_show_type show;
    gtl_view_type view;
    int n_errors = 0;
    int check_count = 0;

    gtl_panel_model i_panel (.i_clk(clk), .o_pulse(pulse), .o_dir_level(dir),
        .o_remote_reset(rem_rst), .o_remote_grand_clear(rem_gc),
        .o_button_grand_clear(btn_gc), .o_button_view(btn_view));

    gtl_top #(.FLASH_CYC(FL), .LABEL_CYC(FL)) i_dut (.I_CLOCK(clk), .I_RESET(rst),
        .I_PULSE(pulse), .I_DIR_LEVEL(dir), .I_REMOTE_RESET(rem_rst),
        .I_REMOTE_GRAND_CLEAR(rem_gc), .I_BUTTON_GRAND_CLEAR(btn_gc),
        .I_BUTTON_VIEW(btn_view), .I_DIRECTION_MODE(dir_mode), .I_GRAND_MODE(gmode),
        .I_COMBINED_MODE(comb), .I_GRAND_CLEAR_BY_REMOTE(gc_rem),
        .I_GRAND_CLEAR_BY_BUTTON(gc_btn), .I_LOW_LIMIT_ON(lo_on),
        .I_LOW_WARNING_LIMIT(lo_lim), .I_HIGH_LIMIT_ON(hi_on),
        .I_HIGH_WARNING_LIMIT(hi_lim), .I_WARNING_STYLE(style),
        .I_POWER_ON_TOTAL_CLEAR(po_tot), .I_POWER_ON_GRAND_CLEAR(po_grand),
        .I_RESET_OPTION(rst_opt), .I_PRESET_VALUE(preset), .O_TOTAL(tot),
        .O_GRAND_TOTAL(grand), .O_LOW_WARNING(lw), .O_HIGH_WARNING(hw),
        .O_SHOW(show), .O_VIEW(view), .O_LABEL(label));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Small offset past the edge so registered outputs have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic pulse_chk(input logic up, input logic signed [31:0] dg);
        i_panel.send_pulse(up);
        exp_t = up ? exp_t + 32'sh1 : exp_t - 32'sh1;
        exp_g = exp_g + dg;
        settle(2);
        chk("total", exp_t, tot);
        chk("grand", exp_g, grand);
    endtask

    task automatic do_reset(input gtl_rst_type pt, input logic pg);
        @(posedge clk);
        po_tot   <= pt;
        po_grand <= pg;
        rst      <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(4);
    endtask

    // Every sample must be a or b, and both must turn up within four flash periods
    task automatic watch_show(input string nm, input gtl_show_type a, input gtl_show_type b);
        int na = 0;
        int nb = 0;
        int no = 0;
        repeat (4 * FL) begin
            settle(1);
            if (show === a) na++;
            else if (show === b) nb++;
            else no++;
        end
        // One state per flash period, so a 4-period window splits evenly
        chk({nm, "_other"}, 32'h0, 32'(no));
        chk({nm, "_first"}, 32'((a == b) ? 4 * FL : 2 * FL), 32'(na));
        chk({nm, "_second"}, 32'((a == b) ? 0 : 2 * FL), 32'(nb));
    endtask

    task automatic load_total(input gtl_rst_type opt, input logic signed [31:0] v);
        @(posedge clk);
        rst_opt <= opt;
        preset  <= v;
        i_panel.press(0);
        exp_t = (opt == GTL_RST_PRESET) ? v : 32'sh0;
        settle(3);
        chk("total_load", exp_t, tot);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_grand_modes();
        gtl_gt_mode_type md [8] = '{GTL_GT_NONE, GTL_GT_FOLLOW, GTL_GT_REVERSE,
            GTL_GT_UP_ONLY, GTL_GT_DN_ONLY, GTL_GT_ANY, GTL_GT_RSVD, gtl_gt_mode_type'(3'h7)};
        int du [8] = '{0, 1, -1, 1, 0, 1, 0, 0};
        int dd [8] = '{0, -1, 1, 0, 1, 1, 0, 0};
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            gmode <= md[i];
            i_panel.press(2);
            exp_g = 32'sh0;
            settle(3);
            chk("grand_clear", exp_g, grand);
            pulse_chk(1'b0, 32'(dd[i]));
            pulse_chk(1'b1, 32'(du[i]));
        end
    endtask

    task automatic test_clear_enables();
        @(posedge clk);
        gmode  <= GTL_GT_ANY;
        gc_btn <= 1'b0;
        pulse_chk(1'b1, 32'sh1);
        i_panel.press(2);
        i_panel.press(1);
        settle(3);
        chk("grand_refused", exp_g, grand);
        @(posedge clk);
        gc_rem <= 1'b1;
        i_panel.press(1);
        exp_g = 32'sh0;
        settle(3);
        chk("grand_remote", exp_g, grand);
    endtask

    task automatic test_direction();
        gtl_dir_type dm [2] = '{GTL_DIR_UP, GTL_DIR_DOWN};
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            gmode    <= GTL_GT_FOLLOW;
            dir_mode <= dm[i];
            // Level opposes the fixed direction, so a leak would show
            i_panel.send_pulse(dm[i] == GTL_DIR_DOWN);
            exp_t = (i == 0) ? exp_t + 32'sh1 : exp_t - 32'sh1;
            exp_g = (i == 0) ? exp_g + 32'sh1 : exp_g - 32'sh1;
            settle(2);
            chk("total_fixed_dir", exp_t, tot);
            chk("grand_fixed_dir", exp_g, grand);
        end
        @(posedge clk);
        gmode    <= GTL_GT_ANY;
        dir_mode <= GTL_DIR_EXT;
    endtask

    task automatic test_warnings();
        @(posedge clk);
        lo_lim <= 32'sh5;
        hi_lim <= 32'sh64;
        lo_on  <= 1'b1;
        hi_on  <= 1'b1;
        load_total(GTL_RST_PRESET, 32'sh3);
        load_total(GTL_RST_ZERO, 32'sh0);
        load_total(GTL_RST_PRESET, 32'sh3);
        chk("low_warn", 32'h1, 32'(lw));
        chk("high_warn", 32'h0, 32'(hw));
        watch_show("none", GTL_SHOW_VALUE, GTL_SHOW_VALUE);
        @(posedge clk);
        style <= GTL_WS_FLASH;
        watch_show("flash", GTL_SHOW_VALUE, GTL_SHOW_BLANK);
        @(posedge clk);
        style <= GTL_WS_DASH;
        watch_show("dash", GTL_SHOW_DASH, GTL_SHOW_BLANK);
        @(posedge clk);
        style <= GTL_WS_HILO;
        watch_show("low_text", GTL_SHOW_LOW, GTL_SHOW_BLANK);
        @(posedge clk);
        lo_on <= 1'b0;
        settle(4);
        chk("low_off", 32'h0, 32'(lw));
        watch_show("low_off_show", GTL_SHOW_VALUE, GTL_SHOW_VALUE);
        load_total(GTL_RST_PRESET, 32'shC8);
        chk("high_warn_on", 32'h1, 32'(hw));
        watch_show("high_text", GTL_SHOW_HIGH, GTL_SHOW_BLANK);
        @(posedge clk);
        style <= GTL_WS_OVUN;
        watch_show("over", GTL_SHOW_HIGH, GTL_SHOW_BLANK);
        @(posedge clk);
        lo_on <= 1'b1;
        load_total(GTL_RST_PRESET, 32'sh32);
        chk("inside_low", 32'h0, 32'(lw));
        chk("inside_high", 32'h0, 32'(hw));
        watch_show("inside", GTL_SHOW_VALUE, GTL_SHOW_VALUE);
    endtask

    task automatic test_view();
        gtl_view_type seq [5] = '{GTL_VIEW_GRAND, GTL_VIEW_TOTAL, GTL_VIEW_GRAND,
            GTL_VIEW_RATE, GTL_VIEW_TOTAL};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            comb <= (i >= 2);
            i_panel.press(3);
            settle(1);
            chk("label_on", 32'h1, 32'(label));
            settle(3 * FL);
            chk("label_off", 32'h0, 32'(label));
            chk("view", 32'(seq[i]), 32'(view));
        end
    endtask

    task automatic test_power_up();
        pulse_chk(1'b1, 32'sh1);
        do_reset(GTL_RST_OFF, 1'b0);
        chk("total_kept", exp_t, tot);
        chk("grand_kept", exp_g, grand);
        @(posedge clk);
        preset <= 32'sh7;
        do_reset(GTL_RST_PRESET, 1'b1);
        chk("total_preset", 32'sh7, tot);
        chk("grand_zero", 32'sh0, grand);
    endtask

    task automatic complete_run();
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        comb = 1'b0;
        gc_rem = 1'b0;
        gc_btn = 1'b1;
        lo_on = 1'b0;
        hi_on = 1'b0;
        po_grand = 1'b1;
        lo_lim = 32'sh0;
        hi_lim = 32'sh0;
        preset = 32'sh0;
        dir_mode = GTL_DIR_EXT;
        gmode = GTL_GT_NONE;
        style = GTL_WS_NONE;
        po_tot = GTL_RST_ZERO;
        rst_opt = GTL_RST_ZERO;
        exp_t = 32'sh0;
        exp_g = 32'sh0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        settle(4);
        chk("total_power_up", exp_t, tot);
        chk("grand_power_up", exp_g, grand);
        test_grand_modes();
        test_clear_enables();
        test_direction();
        test_warnings();
        test_view();
        test_power_up();
        complete_run();
    end
endmodule // test_grand_total_limit_warning
`default_nettype wire
